//--- rtl/clk_sel_pkg.sv
// Purpose: constants and types for the system clock select and divide block
// Assumes: oscillators arrive as levels sampled on clk; 8-bit register port
// Notes:   source codes double as indexes into per-source vectors
//
// Notes on behaviour
// - select code 00 fast osc, 01 external input, 10 slow osc, 11 reserved
// - select field reads back as written; reads need not show the running source
// - switch register bit 5 reads 1 when fast osc enabled and stable, or during flash programming
// - switch register bit 3 reads 1 only when external input enabled, stable
// - external input enabled only for enable field 11; else pin is port bit
// - enable register bit 5 runs or stops the fast oscillator
// - flash programming forces fast osc on and its bits set, then restores
// - bit 0 fault flag set on switch to unstable or disabled source
// - reset leaves fast osc on, external off, enable register 0011 0000b
// - switch and enable registers written only inside timed-access window
// - divider 00h passes clock, 01h..ffh divides by twice the value
// - divider may change anytime without stall; resets to zero
// - output enable bit 1 drives system clock onto output pin
// - output pin stops toggling in power-down since system clock halts
// - attempts to disable the running source are ignored entirely
// - write to disabled source updates field, keeps clock, sets fault
// - unstable target: keep clock, switch once stable, then clear fault
// - slow oscillator runs from power-up regardless of enables
package clk_sel_pkg;
  // register offsets
  localparam logic [7:0] ADDR_MISC   = 8'h8e;
  localparam logic [7:0] ADDR_DIV    = 8'h95;
  localparam logic [7:0] ADDR_SWITCH = 8'h96;
  localparam logic [7:0] ADDR_ENABLE = 8'h97;
  // reset values
  localparam logic [7:0] RST_MISC    = 8'h00;
  localparam logic [7:0] RST_DIV     = 8'h00;
  localparam logic [7:0] RST_SWITCH  = 8'h30;
  localparam logic [7:0] RST_ENABLE  = 8'h30;
  // field positions
  localparam int SW_FAST_ST  = 5;
  localparam int SW_SLOW_ST  = 4;
  localparam int SW_EXT_ST   = 3;
  localparam int SW_SEL_LO   = 1;
  localparam int EN_EXT_LO   = 6;
  localparam int EN_FAST     = 5;
  localparam int EN_RSVD_ONE = 4;
  localparam int EN_FAULT    = 0;
  localparam int MISC_OUT_EN = 1;
  localparam logic [1:0] EXT_ON_CODE = 2'h3;
  // source edges counted before a source reads stable
  localparam logic [7:0] WARMUP_EDGES = 8'h10;

  typedef enum logic [1:0] {
    SRC_FAST = 2'h0,
    SRC_EXT  = 2'h1,
    SRC_SLOW = 2'h2,
    SRC_RSVD = 2'h3
  } src_e;

  typedef enum logic [2:0] {
    SW_IDLE  = 3'h1,
    SW_WAIT  = 3'h2,
    SW_APPLY = 3'h4
  } sw_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } reg_req_s;
endpackage

//--- rtl/clk_sel_top.sv
// Purpose: system clock source select, stability tracking, divider, clock out
// Assumes: ta_open comes from the timed-access guard outside this block
// Notes:   read data appear the cycle after the read strobe, zero otherwise
`timescale 1ns/1ps
`default_nettype none
module clk_sel_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // register port
  input  wire clk_sel_pkg::reg_req_s reg_req,
  output logic [7:0]                 rdata,
  // oscillator levels, index is the source code
  input  wire logic [2:0]            osc_lvl,
  // system controls
  input  wire logic                  ta_open,
  input  wire logic                  flash_program_enable,
  input  wire logic                  power_down,
  // oscillator and pin controls
  output logic                       fast_osc_run,
  output logic                       ext_input_on,
  output logic                       shared_port_gpio,
  // system clock and its output pin
  output logic                       sysclk,
  output logic                       sysclk_out_pin_o,
  output logic                       sysclk_out_pin_oe
);
  // stored register fields
  logic [1:0]              ext_en_q;
  logic                    fast_en_q;
  logic                    fault_q;
  logic [1:0]              sel_q;
  logic [7:0]              div_q;
  logic                    out_en_q;
  logic [7:0]              rdata_q;
  // switch control
  clk_sel_pkg::sw_state_e  state_q;
  clk_sel_pkg::src_e       pend_q;
  clk_sel_pkg::src_e       req_src_q;
  clk_sel_pkg::src_e       cur_src;
  clk_sel_pkg::src_e       tgt;
  // per-source vectors, entry 3 is the reserved code
  logic [3:0]              src_en;
  logic [3:0]              stable;
  logic [3:0]              lvl4;
  // decodes
  logic                    wr_misc;
  logic                    wr_div;
  logic                    wr_sw;
  logic                    wr_en;
  logic                    new_fast;
  logic                    new_ext;
  logic                    en_reject;
  logic                    fast_eff;
  logic [7:0]              sw_view;
  logic [7:0]              en_view;
  logic [7:0]              rd_mux;

  // source enables; slow osc never stops
  assign fast_eff    = fast_en_q | flash_program_enable;
  assign src_en[0]   = fast_eff;
  assign src_en[1]   = (ext_en_q == clk_sel_pkg::EXT_ON_CODE);
  assign src_en[2]   = 1'b1;
  assign src_en[3]   = 1'b0;
  assign lvl4        = {1'b0, osc_lvl};
  assign stable[3]   = 1'b0;

  // one warm-up tracker per source
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_trk
      osc_warmup #(
        .RST_STABLE (gi != 1)
      ) u_trk (
        .clk     (clk),
        .arst_n  (arst_n),
        .enable  (src_en[gi]),
        .osc_lvl (osc_lvl[gi]),
        .stable  (stable[gi])
      );
    end
  endgenerate

  // clock mux and divider
  sysclk_gen u_gen (
    .clk     (clk),
    .arst_n  (arst_n),
    .osc_lvl (lvl4),
    .req_src (req_src_q),
    .req_div (div_q),
    .halt    (power_down),
    .sysclk  (sysclk),
    .cur_src (cur_src)
  );

  // write decode, protected registers need the open window
  assign wr_misc = reg_req.we && reg_req.addr == clk_sel_pkg::ADDR_MISC;
  assign wr_div  = reg_req.we && reg_req.addr == clk_sel_pkg::ADDR_DIV;
  assign wr_sw   = reg_req.we && reg_req.addr == clk_sel_pkg::ADDR_SWITCH
                   && ta_open;
  assign wr_en   = reg_req.we && reg_req.addr == clk_sel_pkg::ADDR_ENABLE
                   && ta_open;
  assign tgt     = clk_sel_pkg::src_e'(reg_req.wdata[clk_sel_pkg::SW_SEL_LO +: 2]);

  // an enable write that would stop the running or requested source
  assign new_fast  = reg_req.wdata[clk_sel_pkg::EN_FAST];
  assign new_ext   = reg_req.wdata[clk_sel_pkg::EN_EXT_LO +: 2] == clk_sel_pkg::EXT_ON_CODE;
  assign en_reject = (!new_fast && (cur_src == clk_sel_pkg::SRC_FAST
                                    || req_src_q == clk_sel_pkg::SRC_FAST))
                  || (!new_ext && (cur_src == clk_sel_pkg::SRC_EXT
                                   || req_src_q == clk_sel_pkg::SRC_EXT));

  // enable register, written unless en_reject; flash override is applied in fast_eff
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_en_q  <= clk_sel_pkg::RST_ENABLE[clk_sel_pkg::EN_EXT_LO +: 2];
      fast_en_q <= clk_sel_pkg::RST_ENABLE[clk_sel_pkg::EN_FAST];
    end else if (wr_en && !en_reject) begin
      ext_en_q  <= reg_req.wdata[clk_sel_pkg::EN_EXT_LO +: 2];
      fast_en_q <= new_fast;
    end
  end

  // plain registers: divider and clock output enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q    <= clk_sel_pkg::RST_DIV;
      out_en_q <= clk_sel_pkg::RST_MISC[clk_sel_pkg::MISC_OUT_EN];
    end else begin
      if (wr_div)
        div_q <= reg_req.wdata;
      if (wr_misc)
        out_en_q <= reg_req.wdata[clk_sel_pkg::MISC_OUT_EN];
    end
  end

  // switch sequencing; a new write wins over completion so faults are kept
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= clk_sel_pkg::SW_IDLE;
      pend_q    <= clk_sel_pkg::SRC_FAST;
      req_src_q <= clk_sel_pkg::SRC_FAST;
      sel_q     <= clk_sel_pkg::RST_SWITCH[clk_sel_pkg::SW_SEL_LO +: 2];
      fault_q   <= clk_sel_pkg::RST_ENABLE[clk_sel_pkg::EN_FAULT];
    end else if (wr_sw) begin
      sel_q <= tgt;
      if (!src_en[tgt]) begin
        fault_q <= 1'b1;
        state_q <= clk_sel_pkg::SW_IDLE;
      end else if (tgt == req_src_q) begin
        fault_q <= 1'b0;
        state_q <= (cur_src == tgt) ? clk_sel_pkg::SW_IDLE : clk_sel_pkg::SW_APPLY;
      end else if (stable[tgt]) begin
        req_src_q <= tgt;
        fault_q   <= 1'b0;
        state_q   <= clk_sel_pkg::SW_APPLY;
      end else begin
        pend_q  <= tgt;
        fault_q <= 1'b1;
        state_q <= clk_sel_pkg::SW_WAIT;
      end
    end else begin
      unique case (state_q)
        clk_sel_pkg::SW_IDLE: begin
          state_q <= clk_sel_pkg::SW_IDLE;
        end
        clk_sel_pkg::SW_WAIT: begin
          if (!src_en[pend_q]) begin
            state_q <= clk_sel_pkg::SW_IDLE;
          end else if (stable[pend_q]) begin
            req_src_q <= pend_q;
            state_q   <= clk_sel_pkg::SW_APPLY;
          end
        end
        clk_sel_pkg::SW_APPLY: begin
          if (cur_src == req_src_q) begin
            fault_q <= 1'b0;
            state_q <= clk_sel_pkg::SW_IDLE;
          end
        end
        default: begin
          state_q <= clk_sel_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // read views; select field reads back as written, not the live source
  assign sw_view = {2'h0,
                    stable[0] | flash_program_enable,
                    stable[2],
                    stable[1],
                    sel_q,
                    1'b0};
  assign en_view = {ext_en_q,
                    fast_eff,
                    clk_sel_pkg::RST_ENABLE[clk_sel_pkg::EN_RSVD_ONE],
                    3'h0,
                    fault_q};
  assign rd_mux  = (reg_req.addr == clk_sel_pkg::ADDR_MISC)   ? {6'h00, out_en_q, 1'b0} :
                   (reg_req.addr == clk_sel_pkg::ADDR_DIV)    ? div_q :
                   (reg_req.addr == clk_sel_pkg::ADDR_SWITCH) ? sw_view :
                   (reg_req.addr == clk_sel_pkg::ADDR_ENABLE) ? en_view : 8'h00;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= reg_req.re ? rd_mux : 8'h00;
  end

  // outputs
  assign rdata             = rdata_q;
  assign fast_osc_run      = src_en[0];
  assign ext_input_on      = src_en[1];
  assign shared_port_gpio  = ~src_en[1];
  assign sysclk_out_pin_o  = sysclk;
  assign sysclk_out_pin_oe = out_en_q;

  property p_guard_blocks;
    @(posedge clk) disable iff (!arst_n)
      reg_req.we && reg_req.addr == clk_sel_pkg::ADDR_ENABLE && !ta_open
      |=> $stable(ext_en_q) && $stable(fast_en_q);
  endproperty
  a_guard_blocks: assert property (p_guard_blocks)
    else $error("enable register changed outside access window");

  property p_fault_disabled;
    @(posedge clk) disable iff (!arst_n)
      wr_sw && !src_en[tgt] |=> fault_q && $stable(req_src_q);
  endproperty
  a_fault_disabled: assert property (p_fault_disabled)
    else $error("switch to disabled source not flagged");

  property p_active_enabled;
    @(posedge clk) disable iff (!arst_n) src_en[cur_src];
  endproperty
  a_active_enabled: assert property (p_active_enabled)
    else $error("running source became disabled");

  property p_flash_forces;
    @(posedge clk) disable iff (!arst_n)
      flash_program_enable && reg_req.re && reg_req.addr == clk_sel_pkg::ADDR_ENABLE
      |=> rdata[clk_sel_pkg::EN_FAST];
  endproperty
  a_flash_forces: assert property (p_flash_forces)
    else $error("fast osc enable not forced during flash programming");

  property p_ext_on;
    @(posedge clk) disable iff (!arst_n)
      wr_en && !en_reject && new_ext |=> ext_input_on && !shared_port_gpio;
  endproperty
  a_ext_on: assert property (p_ext_on)
    else $error("external input not enabled by code 11");

  property p_div_read;
    @(posedge clk) disable iff (!arst_n)
      wr_div ##1 (reg_req.re && reg_req.addr == clk_sel_pkg::ADDR_DIV && !wr_div)
      |=> rdata == $past(reg_req.wdata, 2);
  endproperty
  a_div_read: assert property (p_div_read)
    else $error("divider read back wrong");

  property p_pd_frozen;
    @(posedge clk) disable iff (!arst_n)
      power_down ##1 power_down |-> $stable(sysclk_out_pin_o);
  endproperty
  a_pd_frozen: assert property (p_pd_frozen)
    else $error("clock output toggled in power-down");

  property p_pin_release;
    @(posedge clk) disable iff (!arst_n)
      wr_misc && !reg_req.wdata[clk_sel_pkg::MISC_OUT_EN] |=> !sysclk_out_pin_oe;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("clock output pin still driven");

  property p_wait_faulted;
    @(posedge clk) disable iff (!arst_n)
      state_q == clk_sel_pkg::SW_WAIT |-> fault_q && cur_src != pend_q;
  endproperty
  a_wait_faulted: assert property (p_wait_faulted)
    else $error("waiting switch without fault or already switched");

  property p_apply_clears;
    @(posedge clk) disable iff (!arst_n)
      state_q == clk_sel_pkg::SW_APPLY && cur_src == req_src_q && !wr_sw
      |=> !fault_q && state_q == clk_sel_pkg::SW_IDLE;
  endproperty
  a_apply_clears: assert property (p_apply_clears)
    else $error("fault not cleared after switch");

  c_to_slow: cover property (@(posedge clk) disable iff (!arst_n)
    cur_src == clk_sel_pkg::SRC_SLOW);
  c_wait_done: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == clk_sel_pkg::SW_WAIT ##1 state_q == clk_sel_pkg::SW_APPLY);
  c_reject: cover property (@(posedge clk) disable iff (!arst_n) wr_en && en_reject);
  c_div_out: cover property (@(posedge clk) disable iff (!arst_n)
    div_q != 8'h00 && sysclk_out_pin_oe && $rose(sysclk));
endmodule
`default_nettype wire

//--- rtl/osc_warmup.sv
// Purpose: warm-up tracker that flags an oscillator stable after enough edges
// Assumes: osc_lvl is a level sampled on clk
// Notes:   RST_STABLE marks sources that are already settled out of reset
`timescale 1ns/1ps
`default_nettype none
module osc_warmup #(
  parameter logic RST_STABLE = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // oscillator
  input  wire logic enable,
  input  wire logic osc_lvl,
  output logic      stable
);
  localparam logic [7:0] CNT_RST = RST_STABLE ? clk_sel_pkg::WARMUP_EDGES : 8'h00;

  logic       prev_q;
  logic [7:0] cnt_q;
  logic       rise;

  // edge detect and warm-up status
  assign rise   = osc_lvl & ~prev_q;
  assign stable = enable & (cnt_q == clk_sel_pkg::WARMUP_EDGES);

  // count edges while enabled, restart when stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b0;
      cnt_q  <= CNT_RST;
    end else begin
      prev_q <= osc_lvl;
      if (!enable)
        cnt_q <= 8'h00;
      else if (rise && cnt_q != clk_sel_pkg::WARMUP_EDGES)
        cnt_q <= cnt_q + 8'h01;
    end
  end

  property p_stable_needs_enable;
    @(posedge clk) disable iff (!arst_n) !enable |=> !stable;
  endproperty
  a_stable_needs_enable: assert property (p_stable_needs_enable)
    else $error("source reads stable while disabled");
endmodule
`default_nettype wire

//--- rtl/sysclk_gen.sv
// Purpose: glitch-free source mux and even divider for the system clock
// Assumes: oscillator levels sampled on clk; halt freezes the clock
// Notes:   new source and divider load only when a high phase ends
`timescale 1ns/1ps
`default_nettype none
module sysclk_gen (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // sources and settings
  input  wire logic [3:0]        osc_lvl,
  input  wire clk_sel_pkg::src_e req_src,
  input  wire logic [7:0]        req_div,
  input  wire logic              halt,
  // result
  output logic                   sysclk,
  output clk_sel_pkg::src_e      cur_src
);
  logic [7:0] div_q;
  logic [7:0] cnt_q;
  logic       prev_q;
  logic       clk_q;
  logic       lvl;
  logic       rise;
  logic       fall;
  logic       tick;
  logic       boundary;

  // selected level and its edges
  assign lvl      = osc_lvl[cur_src];
  assign rise     = lvl & ~prev_q & ~halt;
  assign fall     = ~lvl & prev_q & ~halt;
  // undivided follows both edges, divided toggles every div source periods
  assign tick     = (div_q == 8'h00) ? (rise | fall)
                                     : (rise && cnt_q == div_q - 8'h01);
  assign boundary = tick & clk_q;
  assign sysclk   = clk_q;

  // phase generation and boundary loading
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_src <= clk_sel_pkg::SRC_FAST;
      div_q   <= clk_sel_pkg::RST_DIV;
      cnt_q   <= 8'h00;
      prev_q  <= 1'b0;
      clk_q   <= 1'b0;
    end else if (boundary) begin
      cur_src <= req_src;
      div_q   <= req_div;
      cnt_q   <= 8'h00;
      prev_q  <= osc_lvl[req_src];
      clk_q   <= 1'b0;
    end else begin
      prev_q <= lvl;
      if (tick)
        clk_q <= (div_q == 8'h00) ? rise : ~clk_q;
      if (rise && div_q != 8'h00)
        cnt_q <= (cnt_q == div_q - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    end
  end

  property p_change_on_edge;
    @(posedge clk) disable iff (!arst_n) $changed(clk_q) |-> $past(tick);
  endproperty
  a_change_on_edge: assert property (p_change_on_edge)
    else $error("system clock changed without a source edge");
endmodule
`default_nettype wire

//--- tb/system_clock_select_divide_output_tb.sv
// Purpose: self-checking bench for clock source select, divider and clock out
// Assumes: osc model toggles per clk: fast 1 cycle, ext 2, slow 4 per phase
// Notes:   table loop for plain register cases, hand tests for switching after it
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_divide_output_tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic [7:0] exp;
  } row_s;

  logic                  clk;
  logic                  arst_n;
  clk_sel_pkg::reg_req_s reg_req;
  logic [7:0]            rdata;
  logic [2:0]            osc_lvl;
  logic                  ta_open;
  logic                  flash_program_enable;
  logic                  power_down;
  logic                  fast_osc_run;
  logic                  ext_input_on;
  logic                  shared_port_gpio;
  logic                  sysclk;
  logic                  pin_o;
  logic                  pin_oe;
  logic                  sys_prev;
  logic                  pin_prev;
  logic [1:0]            tick;
  logic [7:0]            rd_val;
  int                    mismatches;
  int                    n_compared;
  int                    cyc;
  int                    n_sys;
  int                    n_pin;
  row_s                  rows [10];

  clk_sel_top DUT (
    .clk                  (clk),
    .arst_n               (arst_n),
    .reg_req              (reg_req),
    .rdata                (rdata),
    .osc_lvl              (osc_lvl),
    .ta_open              (ta_open),
    .flash_program_enable (flash_program_enable),
    .power_down           (power_down),
    .fast_osc_run         (fast_osc_run),
    .ext_input_on         (ext_input_on),
    .shared_port_gpio     (shared_port_gpio),
    .sysclk               (sysclk),
    .sysclk_out_pin_o     (pin_o),
    .sysclk_out_pin_oe    (pin_oe)
  );

  // 100 MHz bench clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // oscillator model: fast runs only while enabled, ext pin and slow run free
  always @(posedge clk) begin
    tick <= tick + 2'h1;
    if (fast_osc_run === 1'b1) begin
      osc_lvl[0] <= ~osc_lvl[0];
    end
    if (tick[0]) begin
      osc_lvl[1] <= ~osc_lvl[1];
    end
    if (tick == 2'h3) begin
      osc_lvl[2] <= ~osc_lvl[2];
    end
    sys_prev <= sysclk;
    pin_prev <= pin_o;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string what);
    n_compared++;
    if (got != exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    reg_req <= '0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, "register read");
  endtask

  // cycles between sysclk rising edges, bounded
  task automatic wait_rise(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (!(sysclk === 1'b1 && sys_prev === 1'b0) && c < 1000);
    if (c >= 1000) begin
      mismatches++;
      $display("MISMATCH t=%0t sysclk never rose", $time);
      summarize();
    end
  endtask

  task automatic measure(input int exp);
    int c;
    wait_rise(c);
    wait_rise(c);
    wait_rise(c);
    chk_n(c, exp, "sysclk period");
  endtask

  // rising edges of sysclk and of the output pin over n cycles
  task automatic count_rises(input int n, output int s, output int p);
    s = 0;
    p = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (sysclk === 1'b1 && sys_prev === 1'b0) s++;
      if (pin_o === 1'b1 && pin_prev === 1'b0) p++;
    end
  endtask

  initial begin
    arst_n = 1'b0;
    reg_req = '0;
    osc_lvl = 3'h0;
    tick = 2'h0;
    ta_open = 1'b0;
    flash_program_enable = 1'b0;
    power_down = 1'b0;
    mismatches = 0;
    n_compared = 0;
    rows = '{
      '{8'h8e, 8'h00, 1'b0, 8'h00}, '{8'h95, 8'h00, 1'b0, 8'h00},
      '{8'h96, 8'h00, 1'b0, 8'h30}, '{8'h97, 8'h00, 1'b0, 8'h30},
      '{8'h10, 8'h00, 1'b0, 8'h00}, '{8'h8e, 8'hff, 1'b1, 8'h02},
      '{8'h8e, 8'h00, 1'b1, 8'h00}, '{8'h95, 8'hff, 1'b1, 8'hff},
      '{8'h96, 8'h06, 1'b1, 8'h30}, '{8'h97, 8'h00, 1'b1, 8'h30}};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(fast_osc_run, 1'b1, "fast osc at reset");
    chk(ext_input_on, 1'b0, "ext input at reset");
    chk(shared_port_gpio, 1'b1, "port bit at reset");
    chk(pin_oe, 1'b0, "clock pin at reset");
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
      rc(rows[i].addr, rows[i].exp);
    end
    @(posedge clk);
    #1;
    chk(rdata, 8'h00, "read data after its cycle");
    $display("test register table done");
    // divider: undivided, then twice the value
    wr(clk_sel_pkg::ADDR_DIV, 8'h00);
    measure(2);
    wr(clk_sel_pkg::ADDR_DIV, 8'h01);
    measure(4);
    // write then read the divider back to back, no gap
    @(posedge clk);
    reg_req <= '{addr: clk_sel_pkg::ADDR_DIV, wdata: 8'h03, we: 1'b1, re: 1'b0};
    @(posedge clk);
    reg_req <= '{addr: clk_sel_pkg::ADDR_DIV, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    #1;
    chk(rdata, 8'h03, "divider back to back");
    measure(12);
    wr(clk_sel_pkg::ADDR_DIV, 8'h00);
    measure(2);
    $display("test divider done");
    // clock output pin, then power-down freeze
    wr(clk_sel_pkg::ADDR_MISC, 8'h02);
    count_rises(40, n_sys, n_pin);
    chk(pin_oe, 1'b1, "clock pin enabled");
    chk_n(n_pin, 20, "pin follows sysclk");
    @(posedge clk);
    power_down <= 1'b1;
    repeat (4) @(posedge clk);
    count_rises(20, n_sys, n_pin);
    chk_n(n_sys + n_pin, 0, "clock frozen in power-down");
    @(posedge clk);
    power_down <= 1'b0;
    wr(clk_sel_pkg::ADDR_MISC, 8'h00);
    @(posedge clk);
    #1;
    chk(pin_oe, 1'b0, "clock pin released");
    $display("test clock out done");
    // switch to disabled external, enable it, switch while unstable
    @(posedge clk);
    ta_open <= 1'b1;
    wr(clk_sel_pkg::ADDR_SWITCH, 8'h02);
    rc(clk_sel_pkg::ADDR_ENABLE, 8'h31);
    rc(clk_sel_pkg::ADDR_SWITCH, 8'h32);
    measure(2);
    wr(clk_sel_pkg::ADDR_ENABLE, 8'hf0);
    chk(ext_input_on, 1'b1, "ext input on");
    chk(shared_port_gpio, 1'b0, "port bit taken");
    wr(clk_sel_pkg::ADDR_SWITCH, 8'h02);
    rc(clk_sel_pkg::ADDR_ENABLE, 8'hf1);
    cyc = 0;
    do begin
      rd(clk_sel_pkg::ADDR_ENABLE, rd_val);
      cyc++;
    end while (rd_val[0] !== 1'b0 && cyc < 100);
    chk_n(cyc < 100, 1, "fault cleared once stable");
    rc(clk_sel_pkg::ADDR_SWITCH, 8'h3a);
    measure(4);
    wr(clk_sel_pkg::ADDR_ENABLE, 8'h30);
    rc(clk_sel_pkg::ADDR_ENABLE, 8'hf0);
    $display("test external switch done");
    // back to fast, drop external with a non-enabling code
    wr(clk_sel_pkg::ADDR_SWITCH, 8'h00);
    measure(2);
    wr(clk_sel_pkg::ADDR_ENABLE, 8'hb0);
    chk(ext_input_on, 1'b0, "ext input off");
    chk(shared_port_gpio, 1'b1, "port bit back");
    wr(clk_sel_pkg::ADDR_ENABLE, 8'h00);
    rc(clk_sel_pkg::ADDR_ENABLE, 8'hb0);
    chk(fast_osc_run, 1'b1, "running fast kept");
    // slow source, then stop fast
    wr(clk_sel_pkg::ADDR_SWITCH, 8'h04);
    measure(8);
    wr(clk_sel_pkg::ADDR_ENABLE, 8'h10);
    chk(fast_osc_run, 1'b0, "fast stopped");
    rc(clk_sel_pkg::ADDR_SWITCH, 8'h14);
    $display("test slow switch done");
    // flash programming override and restore
    @(posedge clk);
    flash_program_enable <= 1'b1;
    @(posedge clk);
    #1;
    chk(fast_osc_run, 1'b1, "fast forced on");
    rc(clk_sel_pkg::ADDR_ENABLE, 8'h30);
    rc(clk_sel_pkg::ADDR_SWITCH, 8'h34);
    @(posedge clk);
    flash_program_enable <= 1'b0;
    rc(clk_sel_pkg::ADDR_ENABLE, 8'h10);
    chk(fast_osc_run, 1'b0, "fast restored off");
    // reserved select code faults and keeps the clock
    wr(clk_sel_pkg::ADDR_SWITCH, 8'h06);
    rc(clk_sel_pkg::ADDR_ENABLE, 8'h11);
    measure(8);
    $display("test flash and reserved done");
    summarize();
  end
endmodule
`default_nettype wire
